/* File: wdtp_pkg.sv */
// Constants shared by the prescaled watchdog: register word indices, field layouts,
// reset values, state codes and the low-frequency clock derivation.
// Assumes a single 125 MHz system clock and an Avalon-MM register bus.
package wdtp_pkg;

  // System clock and nominal low-frequency oscillator rate.
  localparam int CLK_HZ = 125_000_000;
  localparam int LF_HZ  = 31_000;
  // System cycles per low-frequency tick, rounded down.
  localparam int LF_DIV = CLK_HZ / LF_HZ;
  localparam int LF_W   = 12;

  // Register word indices; the byte address is four times the index.
  localparam logic [13:0] IDX_OPTION   = 14'h0081;
  localparam logic [13:0] IDX_CONTROL  = 14'h0097;
  localparam logic [13:0] IDX_FUSE     = 14'h2007;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h0098;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h0099;
  localparam logic [13:0] IDX_STATE    = 14'h009A;

  // Control register layout and reset value.
  localparam logic [7:0] CTL_RST       = 8'h08;
  localparam logic [7:0] CTL_IMPL_MASK = 8'h1F;
  localparam int         CTL_EN_BIT    = 0;
  localparam int         CTL_PS_LSB    = 1;
  localparam logic [3:0] PS_MAX_CODE   = 4'hB;
  localparam int         PRE_BASE_SH   = 5;
  localparam int         PRE_W         = 17;

  // Timer option register layout and reset value.
  localparam logic [7:0] OPT_RST      = 8'hFF;
  localparam int         OPT_PSA_BIT  = 3;
  localparam int         POST_W       = 8;

  // Fuse word layout and reset value.
  localparam logic [7:0] FUSE_RST      = 8'h00;
  localparam int         FUSE_FUSE_WATCHDOG_FORCE_ON_BIT = 3;

  // Event bits of the interrupt status and mask registers.
  localparam int         EV_W     = 2;
  localparam int         EV_RESET = 0;
  localparam int         EV_WAKE  = 1;
  localparam logic [1:0] EV_NONE  = 2'h0;

  // Time-out flag (active low) value after reset.
  localparam logic       EXP_N_RST = 1'b1;

  // Power state of the processor as the watchdog sees it.
  typedef enum logic [1:0] {
    ST_AWAKE  = 2'b01,
    ST_ASLEEP = 2'b10
  } wdtp_state_t;

endpackage : wdtp_pkg

/* File: wdtp_div_if.sv */
// Connection between the watchdog core and one counting divider stage.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface wdtp_div_if #(parameter int W = 8);
  logic         clr;
  logic         step;
  logic [W-1:0] limit;
  logic         tick;
  modport div_side (input clr, input step, input limit, output tick);
  modport user_side (output clr, output step, output limit, input tick);
endinterface : wdtp_div_if

/* File: wdtp_divider.sv */
// One divider stage: counts step pulses and emits a tick every limit+1 steps.
// Assumes step is a one-cycle enable on clk_sys; clr zeroes the count and the tick.
`timescale 1ns/100ps
module wdtp_divider #(
  parameter int W = 8
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Divider connection.
  wdtp_div_if.div_side div
);

  logic [W-1:0] cnt;

  // Count steps; wrap and tick at the limit, also when the limit shrank mid-count.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || div.clr)
    begin
      cnt      <= '0;
      div.tick <= 1'b0;
    end
    else
    begin
      div.tick <= 1'b0;
      if (div.step)
      begin
        if (cnt >= div.limit)
        begin
          cnt      <= '0;
          div.tick <= 1'b1;
        end
        else
          cnt <= cnt + 1'b1;
      end
    end
  end

endmodule : wdtp_divider

/* File: wdtp_top.sv */
// Prescaled watchdog timer with Avalon-MM register access and a level interrupt.
// Assumes processor events arrive as one-cycle pulses synchronous to clk_sys,
// and that the start-up delay indication is a level held while that delay runs.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps

module wdtp_top
  import wdtp_pkg::*;
#(
  // System cycles per low-frequency tick; a bench may shorten it to keep runs brief.
  parameter int LF_TICK_DIV = LF_DIV
)
(
  // Clock and synchronous reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Avalon-MM slave.
  input  wire logic [15:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  // Processor events.
  input  wire logic        clear_watchdog_instruction,
  input  wire logic        osc_fail,
  input  wire logic        sleep_enter,
  input  wire logic        sleep_exit,
  input  wire logic        startup_delay_counter,
  // Watchdog results.
  output      logic        wdt_reset_req,
  output      logic        wdt_wake,
  output      logic        watchdog_expired_flag_n,
  output      logic        wdt_running,
  output      logic        irq
);

  // Registers.
  logic [7:0]      timer_prescale_setup_register;
  logic [7:0]      watchdog_control_register;
  logic [7:0]      fuse_word;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  wdtp_state_t     state;

  // Bus decode.
  logic [13:0] word_idx;
  logic        wr_take;
  logic [7:0]  next_rdata;

  // Watchdog control terms.
  logic            running;
  logic            wdt_clr;
  logic [3:0]      watchdog_period_select;
  logic [3:0]      period_code;
  logic            prescaler_target;
  logic [2:0]      prescaler_rate;
  logic            timeout;
  logic [EV_W-1:0] events;

  // Divider stages.
  wdtp_div_if #(.W(LF_W))   lf_if ();
  wdtp_div_if #(.W(PRE_W))  pre_if ();
  wdtp_div_if #(.W(POST_W)) post_if ();

  assign word_idx = address[15:2];
  assign wr_take  = write && !waitrequest;

  // Accept a request one cycle after it appears; release the wait for one cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else if (!waitrequest)
      waitrequest <= 1'b1;
    else if (read || write)
      waitrequest <= 1'b0;
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb
  begin
    case (word_idx)
      IDX_OPTION:   next_rdata = timer_prescale_setup_register;
      IDX_CONTROL:  next_rdata = watchdog_control_register & CTL_IMPL_MASK;
      IDX_FUSE:     next_rdata = fuse_word;
      IDX_IRQ_STAT: next_rdata = {6'h00, irq_stat};
      IDX_IRQ_MASK: next_rdata = {6'h00, irq_mask};
      IDX_STATE:    next_rdata = {5'h00, state == ST_ASLEEP, watchdog_expired_flag_n, running};
      default:      next_rdata = 8'h00;
    endcase
  end

  // Capture read data while the wait is still high so it stands when it drops.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      readdata <= 32'h0000_0000;
    else if (read && waitrequest)
      readdata <= {24'h00_0000, next_rdata};
  end

  // Control register: reset pattern on any reset, bits 7 to 5 never stored.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      watchdog_control_register <= CTL_RST;
    else if (wr_take && word_idx == IDX_CONTROL)
      watchdog_control_register <= writedata[7:0] & CTL_IMPL_MASK;
  end

  // Timer option and fuse registers, each kept apart from the control register.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      timer_prescale_setup_register <= OPT_RST;
      fuse_word                     <= FUSE_RST;
    end
    else if (wr_take)
    begin
      if (word_idx == IDX_OPTION)
        timer_prescale_setup_register <= writedata[7:0];
      if (word_idx == IDX_FUSE)
        fuse_word <= writedata[7:0];
    end
  end

  // Fuse enable forces running; otherwise the software switch decides.
  assign running = fuse_word[FUSE_FUSE_WATCHDOG_FORCE_ON_BIT] || watchdog_control_register[CTL_EN_BIT];

  // Every condition that zeroes the prescaler and postscaler; the low-frequency stage keeps running.
  assign wdt_clr = !running
                || clear_watchdog_instruction
                || osc_fail
                || sleep_exit
                || sleep_enter
                || startup_delay_counter;

  // Period field decode; reserved codes fall back to the longest ratio.
  assign watchdog_period_select = watchdog_control_register[CTL_PS_LSB +: 4];
  assign period_code = (watchdog_period_select > PS_MAX_CODE) ? PS_MAX_CODE
                                                              : watchdog_period_select;
  assign prescaler_target = timer_prescale_setup_register[OPT_PSA_BIT];
  assign prescaler_rate   = timer_prescale_setup_register[2:0];

  // Low-frequency tick from the system clock, free running.
  assign lf_if.clr   = 1'b0;
  assign lf_if.step  = 1'b1;
  assign lf_if.limit = LF_W'(LF_TICK_DIV - 1);

  // Programmable prescaler, 1:32 up to 1:65536 in doubling steps.
  assign pre_if.clr   = wdt_clr;
  assign pre_if.step  = lf_if.tick;
  assign pre_if.limit = PRE_W'((PRE_W'(1) << (PRE_BASE_SH + 32'(period_code))) - 1);

  // Legacy postscaler, active only when the option register points it here.
  assign post_if.clr   = wdt_clr;
  assign post_if.step  = pre_if.tick;
  assign post_if.limit = prescaler_target ? POST_W'((POST_W'(1) << prescaler_rate) - 1)
                                          : '0;

  wdtp_divider #(.W(LF_W)) u_lf_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .div     (lf_if)
  );

  wdtp_divider #(.W(PRE_W)) u_pre_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .div     (pre_if)
  );

  wdtp_divider #(.W(POST_W)) u_post_div (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .div     (post_if)
  );

  // A time-out counts only while running and not being cleared this cycle.
  assign timeout = post_if.tick && !wdt_clr;

  // Events that feed the sticky status bits.
  assign events[EV_RESET] = timeout && state == ST_AWAKE;
  assign events[EV_WAKE]  = timeout && state == ST_ASLEEP;

  // Sleep tracking: a time-out while asleep returns the processor to work.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state <= ST_AWAKE;
    else
    begin
      case (state)
        ST_AWAKE:
          if (sleep_enter)
            state <= ST_ASLEEP;
        ST_ASLEEP:
          if (sleep_exit || events[EV_WAKE])
            state <= ST_AWAKE;
        default:
          state <= ST_AWAKE;
      endcase
    end
  end

  // Reset request and wake pulses, one cycle each.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wdt_reset_req <= 1'b0;
      wdt_wake      <= 1'b0;
    end
    else
    begin
      wdt_reset_req <= events[EV_RESET];
      wdt_wake      <= events[EV_WAKE];
    end
  end

  // Time-out flag, active low: a time-out clears it, clear or sleep sets it.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      watchdog_expired_flag_n <= EXP_N_RST;
    else if (timeout)
      watchdog_expired_flag_n <= 1'b0;
    else if (clear_watchdog_instruction || sleep_enter)
      watchdog_expired_flag_n <= 1'b1;
  end

  // Running indication for the outside.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      wdt_running <= 1'b0;
    else
      wdt_running <= running;
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_stat <= EV_NONE;
    else if (wr_take && word_idx == IDX_IRQ_STAT)
      irq_stat <= (irq_stat & ~writedata[EV_W-1:0]) | events;
    else
      irq_stat <= irq_stat | events;
  end

  // Interrupt mask register.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq_mask <= EV_NONE;
    else if (wr_take && word_idx == IDX_IRQ_MASK)
      irq_mask <= writedata[EV_W-1:0];
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

  // Helpers read only by the checks below.
  logic irq_pend;
  logic ctl_read;
  assign irq_pend = |(irq_stat & irq_mask);
  assign ctl_read = read && waitrequest && word_idx == IDX_CONTROL;

  AST_CTL_RESET: assert property (@(posedge clk_sys)
    !rst_n |=> watchdog_control_register == CTL_RST && !wdt_running)
    else $error("control register not at reset pattern after reset");

  AST_UNIMPL_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_read |=> readdata[7:5] == 3'h0 && !waitrequest)
    else $error("unimplemented control bits read nonzero");

  AST_FORCE_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fuse_word[FUSE_FUSE_WATCHDOG_FORCE_ON_BIT] |=> wdt_running)
    else $error("fuse enable did not keep watchdog running");

  AST_SW_SWITCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !fuse_word[FUSE_FUSE_WATCHDOG_FORCE_ON_BIT] |=> wdt_running == $past(watchdog_control_register[CTL_EN_BIT]))
    else $error("software switch not followed");

  AST_HOLD_STARTUP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    startup_delay_counter |=> !wdt_reset_req && !wdt_wake)
    else $error("time-out during start-up delay");

  AST_CLEAR_EVENTS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clear_watchdog_instruction || osc_fail || sleep_exit) |=> !wdt_reset_req ##1 !post_if.tick)
    else $error("time-out despite clear");

  AST_AWAKE_TIMEOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (timeout && state == ST_AWAKE) |=> wdt_reset_req && !watchdog_expired_flag_n ##1 !wdt_reset_req)
    else $error("awake time-out did not give one reset pulse");

  AST_SLEEP_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (timeout && state == ST_ASLEEP) |=> wdt_wake && !wdt_reset_req && state == ST_AWAKE
                                        && !watchdog_expired_flag_n)
    else $error("sleep time-out did not wake");

  AST_SLEEP_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sleep_enter && state == ST_AWAKE && !timeout) |=> state == ST_ASLEEP && watchdog_expired_flag_n)
    else $error("sleep entry not handled");

  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
    irq_pend |=> irq)
    else $error("interrupt not raised for pending status");

  AST_WAIT_ONE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !waitrequest |=> waitrequest)
    else $error("wait released for more than one cycle");

  AST_STOPPED_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !running |=> !wdt_reset_req && !wdt_wake)
    else $error("time-out while the watchdog is stopped");

endmodule : wdtp_top

/* File: wdtp_top_tb.sv */
// Self-checking testbench for the prescaled watchdog top module.
// Assumes the Avalon-MM timing and event pulses described for wdtp_top.
`timescale 1ns/100ps
module wdtp_top_tb;
  import wdtp_pkg::*;

  localparam logic [15:0] A_OPT  = 16'h0204;
  localparam logic [15:0] A_CTL  = 16'h025C;
  localparam logic [15:0] A_FUSE = 16'h801C;
  localparam logic [15:0] A_STAT = 16'h0260;
  localparam logic [15:0] A_MASK = 16'h0264;
  localparam logic [15:0] A_NONE = 16'h0300;
  // Shortened low-frequency tick so that every time-out fits a brief run.
  localparam int          LF_TB  = 64;
  // Shortest time-out: code 0, postscaler off, 32 low-frequency ticks of LF_TB cycles.
  localparam int          T_MIN  = 32 * LF_TB;

  logic        clk_sys;
  logic        rst_n;
  logic [15:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        clr_ins;
  logic        osc_fail;
  logic        sleep_enter;
  logic        sleep_exit;
  logic        startup_dly;
  logic        wdt_reset_req;
  logic        wdt_wake;
  logic        flag_n;
  logic        wdt_running;
  logic        irq;
  int          error_cnt;
  int          num_checks;
  logic [31:0] rd;

  // Device under test with every input driven by the bench.
  wdtp_top #(.LF_TICK_DIV(LF_TB)) u_dut (
    .clk_sys                    (clk_sys),
    .rst_n                      (rst_n),
    .address                    (address),
    .read                       (read),
    .write                      (write),
    .writedata                  (writedata),
    .readdata                   (readdata),
    .waitrequest                (waitrequest),
    .clear_watchdog_instruction (clr_ins),
    .osc_fail                   (osc_fail),
    .sleep_enter                (sleep_enter),
    .sleep_exit                 (sleep_exit),
    .startup_delay_counter      (startup_dly),
    .wdt_reset_req              (wdt_reset_req),
    .wdt_wake                   (wdt_wake),
    .watchdog_expired_flag_n    (flag_n),
    .wdt_running                (wdt_running),
    .irq                        (irq)
  );

  // Free-running 125 MHz system clock.
  always #4 clk_sys = ~clk_sys;

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  // Compares one observed value against its expectation.
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Performs one Avalon transfer and holds it until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_sys);
      if (waitrequest === 1'b0)
        break;
    end
    q     = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    if (n == 50)
    begin
      check("bus answer", 32'h0, 32'h1);
      end_of_test();
    end
  endtask : bus

  // Waits n cycles and counts any time-out pulse seen meanwhile.
  task automatic quiet(input int n, input string nm);
    int hits;
    hits = 0;
    repeat (n)
    begin
      @(posedge clk_sys);
      if (wdt_reset_req !== 1'b0 || wdt_wake !== 1'b0)
        hits++;
    end
    check(nm, hits, 0);
  endtask : quiet

  // Waits for a time-out pulse and judges its moment and kind.
  task automatic wait_timeout(input int lo, input int hi, input logic exp_wake);
    int n;
    for (n = 1; n <= hi; n++)
    begin
      @(posedge clk_sys);
      if (wdt_reset_req === 1'b1 || wdt_wake === 1'b1)
        break;
    end
    if (n > hi)
    begin
      check("timeout seen", 32'h0, 32'h1);
      end_of_test();
    end
    check("timeout early", (n >= lo), 32'h1);
    check("wake pulse", wdt_wake, exp_wake);
    check("reset pulse", wdt_reset_req, !exp_wake);
  endtask : wait_timeout

  // Raises the selected events for one cycle: bit 3 clear, 2 osc fail, 1 sleep enter, 0 sleep exit.
  task automatic pulse(input logic [3:0] ev);
    @(posedge clk_sys);
    {clr_ins, osc_fail, sleep_enter, sleep_exit} <= ev;
    @(posedge clk_sys);
    {clr_ins, osc_fail, sleep_enter, sleep_exit} <= 4'h0;
  endtask : pulse

  // Reset values, unmapped access, period codes and unimplemented bits.
  task automatic test_regs;
    bus(1'b0, A_CTL, 32'h0, rd);
    check("control reset", rd, 32'h08);
    bus(1'b0, A_OPT, 32'h0, rd);
    check("option reset", rd, 32'hFF);
    bus(1'b1, A_NONE, 32'hFF, rd);
    bus(1'b0, A_NONE, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    check("running reset", wdt_running, 1'b0);
    for (int c = 0; c < 12; c++)
    begin
      bus(1'b1, A_CTL, c << 1, rd);
      bus(1'b0, A_CTL, 32'h0, rd);
      check("period code", rd, c << 1);
    end
    bus(1'b1, A_CTL, 32'hE0, rd);
    bus(1'b0, A_CTL, 32'h0, rd);
    check("upper bits", rd, 32'h00);
    $display("test_regs done");
  endtask : test_regs

  // Fuse force-on against the software switch.
  task automatic test_enable;
    bus(1'b1, A_FUSE, 32'h08, rd);
    repeat (3) @(posedge clk_sys);
    check("fuse on", wdt_running, 1'b1);
    bus(1'b1, A_FUSE, 32'h00, rd);
    repeat (3) @(posedge clk_sys);
    check("all off", wdt_running, 1'b0);
    bus(1'b1, A_CTL, 32'h01, rd);
    repeat (3) @(posedge clk_sys);
    check("switch on", wdt_running, 1'b1);
    bus(1'b1, A_CTL, 32'h00, rd);
    $display("test_enable done");
  endtask : test_enable

  // Awake time-out delayed by the start-up hold, then interrupt clear.
  task automatic test_awake;
    bus(1'b1, A_OPT, 32'h00, rd);
    bus(1'b1, A_MASK, 32'h03, rd);
    startup_dly <= 1'b1;
    bus(1'b1, A_CTL, 32'h01, rd);
    quiet(2 * T_MIN, "held by startup");
    startup_dly <= 1'b0;
    wait_timeout(T_MIN - LF_TB - 64, T_MIN + 100, 1'b0);
    repeat (3) @(posedge clk_sys);
    check("flag after reset", flag_n, 1'b0);
    check("irq raised", irq, 1'b1);
    bus(1'b0, A_STAT, 32'h0, rd);
    check("stat reset bit", rd, 32'h01);
    bus(1'b1, A_STAT, 32'h01, rd);
    repeat (3) @(posedge clk_sys);
    check("irq cleared", irq, 1'b0);
    pulse(4'h8);
    repeat (2) @(posedge clk_sys);
    check("flag after clear", flag_n, 1'b1);
    $display("test_awake done");
  endtask : test_awake

  // Sleep time-out restarted by an oscillator failure, wake masked off.
  task automatic test_sleep;
    bus(1'b1, A_MASK, 32'h01, rd);
    pulse(4'h2);
    quiet(T_MIN / 2, "asleep early");
    pulse(4'h4);
    quiet(T_MIN - LF_TB - 8, "restart by osc fail");
    wait_timeout(1, LF_TB + 100, 1'b1);
    repeat (3) @(posedge clk_sys);
    check("flag after wake", flag_n, 1'b0);
    check("irq masked", irq, 1'b0);
    bus(1'b0, A_STAT, 32'h0, rd);
    check("stat wake bit", rd, 32'h02);
    bus(1'b1, A_STAT, 32'h02, rd);
    pulse(4'h1);
    quiet(T_MIN - LF_TB - 8, "restart by exit");
    $display("test_sleep done");
  endtask : test_sleep

  // Postscaler switched onto the watchdog at 1:2 doubles the awake time-out.
  task automatic test_post;
    bus(1'b1, A_OPT, 32'h09, rd);
    pulse(4'h8);
    quiet(2 * T_MIN - LF_TB - 8, "postscaler hold");
    wait_timeout(1, LF_TB + 100, 1'b0);
    $display("test_post done");
  endtask : test_post

  // Main sequence: reset for two cycles, then every scenario in turn.
  initial
  begin
    clk_sys     = 1'b0;
    rst_n       = 1'b0;
    address     = 16'h0;
    read        = 1'b0;
    write       = 1'b0;
    writedata   = 32'h0;
    clr_ins     = 1'b0;
    osc_fail    = 1'b0;
    sleep_enter = 1'b0;
    sleep_exit  = 1'b0;
    startup_dly = 1'b0;
    error_cnt   = 0;
    num_checks  = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    test_regs();
    test_enable();
    test_awake();
    test_sleep();
    test_post();
    end_of_test();
  end
endmodule : wdtp_top_tb
